// File: hdl/flash_device.sv
// Serial flash device end: erase, unlock and sleep command handling.
// Assumes link wires arrive asynchronously; all are resynchronised to mclk.
// The array is modelled as one blank bit per 4 KB subsector.
//
// What this block does
// - Subsector wipe leaves the addressed subsector all ones
// - Erase needs the write unlock latch set
// - Host frames subsector wipe: opcode, three address bytes
// - Subsector wipe dropped unless exactly 32 bits
// - Top three address bits are ignored
// - Chip select rise starts cycle; running flag shows it
// - Unlock latch cleared during each erase cycle
// - Protected subsector is not wiped
// - Commands rejected while a cycle runs
// - Reset pin aborts cycle; host waits before select
// - Whole-array wipe sets everything to ones, timed
// - Whole-array wipe needs exactly eight bits
// - Any protection blocks the whole-array wipe
// - Deep sleep ignores all but sleep exit
// - Deselect gives standby; sleep only by command
// - Sleep entry exactly eight bits, then entry delay
// - Power-up always lands in standby
// - Extra clocks on sleep exit reject it
// - Standby follows sleep exit after exit delay
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
module flash_device #(
    parameter int unsigned SUB_WIPE_CYCLES = `FS_SUB_WIPE_TIME_US * `FS_CLK_MHZ,
    parameter int unsigned ARRAY_WIPE_CYCLES = `FS_ARRAY_WIPE_TIME_US * `FS_CLK_MHZ,
    parameter int unsigned SLEEP_ENTRY_CYCLES = `FS_SLEEP_ENTRY_DELAY_US * `FS_CLK_MHZ,
    parameter int unsigned SLEEP_EXIT_CYCLES = `FS_SLEEP_EXIT_DELAY_US * `FS_CLK_MHZ
) (
    input wire logic mclk,
    input wire logic arst_n,
    flash_link_if.device link,
    input wire logic [511:0] protMask,
    input wire logic progMark,
    input wire logic [8:0] progIndex,
    output logic [511:0] blankMap,
    output logic cycleRunning,
    output logic writeUnlock,
    output logic deepSleep,
    output logic standby,
    output logic resetMode
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // True when the frame held exactly the wanted number of bits
    function automatic logic framed(input logic [5:0] cnt, input logic [5:0] want);
        framed = (cnt == want);
    endfunction

    flash_seq_pkg::dev_s r;
    flash_seq_pkg::dev_s next_r;

    logic sclkRise;
    logic csFall;
    logic csRise;
    logic csLow;
    logic mosiBit;
    logic pinRstN;
    logic [7:0] op8;
    logic [7:0] op32;
    logic [8:0] subIdx;
    logic short8;
    logic long32;

    // ------------------------------------------------------------
    // Synchronised pins and frame decode
    // ------------------------------------------------------------
    // Edges are taken between the second stage and a third copy
    assign sclkRise = r.sync2[0] & ~r.prev[0];
    assign csFall = ~r.sync2[1] & r.prev[1];
    assign csRise = r.sync2[1] & ~r.prev[1];
    assign csLow = ~r.sync2[1];
    assign mosiBit = r.sync2[2];
    assign pinRstN = r.sync2[3];
    assign op8 = r.shiftIn[7:0];
    assign op32 = r.shiftIn[31:24];
    assign subIdx = r.shiftIn[20:12];
    assign short8 = framed(r.bitCnt, `FS_LEN_OPCODE);
    assign long32 = framed(r.bitCnt, `FS_LEN_ADDR_CMD);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // One process holds the whole sequencer so all priorities sit together
    always_comb begin
        next_r = r;
        next_r.sync1 = {link.rstN, link.mosi, link.csN, link.sclk};
        next_r.sync2 = r.sync1;
        next_r.prev = r.sync2;
        // Programming by other logic dirties a subsector
        if (progMark) begin
            next_r.blank[progIndex] = 1'b0;
        end
        if (!pinRstN) begin
            next_r.state = flash_seq_pkg::ST_RESET;
            next_r.write_unlock_latch = 1'b0;
            next_r.bitCnt = 6'h00;
            next_r.timer = 32'h0000_0000;
        end else begin
            // Frame shifter runs in every state, so busy frames are simply dropped
            if (csFall) begin
                next_r.bitCnt = 6'h00;
            end else if (sclkRise && csLow) begin
                next_r.shiftIn = {r.shiftIn[30:0], mosiBit};
                // Saturate so an overlong frame never wraps back to a legal length
                if (r.bitCnt != 6'h3F) begin
                    next_r.bitCnt = r.bitCnt + 6'h01;
                end
            end
            case (r.state)
                flash_seq_pkg::ST_STANDBY: begin
                    if (csRise) begin
                        if (short8 && op8 == `FS_OP_WRITE_UNLOCK) begin
                            next_r.write_unlock_latch = 1'b1;
                        end else if (long32 && op32 == `FS_OP_SUB_WIPE) begin
                            if (r.write_unlock_latch && !protMask[subIdx]) begin
                                next_r.state = flash_seq_pkg::ST_CYCLE;
                                next_r.timer = SUB_WIPE_CYCLES - 32'h1;
                                next_r.wholeArray = 1'b0;
                                next_r.target = subIdx;
                                next_r.write_unlock_latch = 1'b0;
                            end
                        end else if (short8 && op8 == `FS_OP_ARRAY_WIPE) begin
                            if (r.write_unlock_latch && !(|protMask)) begin
                                next_r.state = flash_seq_pkg::ST_CYCLE;
                                next_r.timer = ARRAY_WIPE_CYCLES - 32'h1;
                                next_r.wholeArray = 1'b1;
                                next_r.write_unlock_latch = 1'b0;
                            end
                        end else if (short8 && op8 == `FS_OP_SLEEP_ENTRY) begin
                            next_r.state = flash_seq_pkg::ST_SLEEP_WAIT;
                            next_r.timer = SLEEP_ENTRY_CYCLES - 32'h1;
                        end
                    end
                end
                flash_seq_pkg::ST_CYCLE: begin
                    if (r.timer == 32'h0000_0000) begin
                        if (r.wholeArray) begin
                            next_r.blank = '1;
                        end else begin
                            next_r.blank[r.target] = 1'b1;
                        end
                        next_r.state = flash_seq_pkg::ST_STANDBY;
                    end else begin
                        next_r.timer = r.timer - 32'h1;
                    end
                end
                flash_seq_pkg::ST_SLEEP_WAIT: begin
                    if (r.timer == 32'h0000_0000) begin
                        next_r.state = flash_seq_pkg::ST_SLEEP;
                    end else begin
                        next_r.timer = r.timer - 32'h1;
                    end
                end
                flash_seq_pkg::ST_SLEEP: begin
                    if (csRise && short8 && op8 == `FS_OP_SLEEP_EXIT) begin
                        next_r.state = flash_seq_pkg::ST_WAKE_WAIT;
                        next_r.timer = SLEEP_EXIT_CYCLES - 32'h1;
                    end
                end
                flash_seq_pkg::ST_WAKE_WAIT: begin
                    if (r.timer == 32'h0000_0000) begin
                        next_r.state = flash_seq_pkg::ST_STANDBY;
                    end else begin
                        next_r.timer = r.timer - 32'h1;
                    end
                end
                flash_seq_pkg::ST_RESET: begin
                    // Pin released: same as power-up
                    next_r.state = flash_seq_pkg::ST_STANDBY;
                end
                default: begin
                    next_r.state = flash_seq_pkg::ST_STANDBY;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // power-up lands in standby
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            // Pins start at their idle levels, so no false edge or pin reset follows
            r <= '{state: flash_seq_pkg::ST_STANDBY, sync1: `FS_PIN_IDLE, sync2: `FS_PIN_IDLE,
                prev: `FS_PIN_IDLE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign blankMap = r.blank;
    assign cycleRunning = (r.state == flash_seq_pkg::ST_CYCLE);
    assign writeUnlock = r.write_unlock_latch;
    assign deepSleep = (r.state == flash_seq_pkg::ST_SLEEP);
    assign standby = (r.state == flash_seq_pkg::ST_STANDBY) & r.sync2[1];
    assign resetMode = (r.state == flash_seq_pkg::ST_RESET);

endmodule // flash_device

// File: hdl/flash_host.sv
// Serial flash host end: APB-programmed command framer.
// Assumes APB runs on mclk; the serial clock is divided down from mclk.
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
module flash_host #(
    parameter int unsigned SLEEP_ENTRY_CYCLES = `FS_SLEEP_ENTRY_DELAY_US * `FS_CLK_MHZ,
    parameter int unsigned SLEEP_EXIT_CYCLES = `FS_SLEEP_EXIT_DELAY_US * `FS_CLK_MHZ,
    parameter int unsigned RESET_TO_SELECT_CYCLES = `FS_RESET_TO_SELECT_US * `FS_CLK_MHZ
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    flash_link_if.host link
);

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    // True for one of the four mapped word offsets
    function automatic logic mapped(input logic [31:0] a);
        mapped = (a[31:8] == 24'h000000) && (a[7:0] == `FS_REG_CMD || a[7:0] == `FS_REG_ADDR
            || a[7:0] == `FS_REG_STATUS || a[7:0] == `FS_REG_RSTCTL);
    endfunction

    flash_seq_pkg::host_s r;
    flash_seq_pkg::host_s next_r;
    logic busy;
    logic wrAcc;
    logic [5:0] frameLen;

    assign busy = (r.state != flash_seq_pkg::H_IDLE) | r.resetHold;
    assign wrAcc = psel & penable & pwrite & mapped(paddr);
    assign frameLen = pwdata[`FS_CMD_WITH_ADDR] ? `FS_LEN_ADDR_CMD : `FS_LEN_OPCODE;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Zero-wait slave: read data captured in setup, presented in access
    always_comb begin
        next_r = r;
        if (psel && !penable) begin
            next_r.prdata = 32'h0000_0000;
            if (mapped(paddr)) begin
                case (paddr[7:0])
                    `FS_REG_CMD: next_r.prdata = {20'h00000, r.extra, r.withAddr, r.opcode};
                    `FS_REG_ADDR: next_r.prdata = {8'h00, r.addr};
                    `FS_REG_STATUS: next_r.prdata = {30'h0000_0000, r.resetHold, busy};
                    default: next_r.prdata = {31'h0000_0000, r.resetHold};
                endcase
            end
        end
        // Serial framer
        case (r.state)
            flash_seq_pkg::H_IDLE: begin
                next_r.csN = 1'b1;
                next_r.sclk = 1'b0;
            end
            flash_seq_pkg::H_LEAD: begin
                next_r.csN = 1'b0;
                next_r.phase = r.phase + 4'h1;
                if (r.phase == `FS_SCLK_HALF - 4'h1) begin
                    next_r.state = flash_seq_pkg::H_BIT;
                    next_r.phase = 4'h0;
                    next_r.mosi = r.shiftOut[31];
                end
            end
            flash_seq_pkg::H_BIT: begin
                // Data moves on the falling edge, device samples on the rising one
                next_r.phase = r.phase + 4'h1;
                next_r.sclk = (r.phase >= `FS_SCLK_HALF - 4'h1);
                if (r.phase == (`FS_SCLK_HALF << 1) - 4'h1) begin
                    next_r.sclk = 1'b0;
                    next_r.phase = 4'h0;
                    next_r.shiftOut = {r.shiftOut[30:0], 1'b0};
                    next_r.mosi = r.shiftOut[30];
                    next_r.bitsLeft = r.bitsLeft - 6'h01;
                    if (r.bitsLeft == 6'h01) begin
                        next_r.state = flash_seq_pkg::H_TAIL;
                    end
                end
            end
            flash_seq_pkg::H_TAIL: begin
                next_r.phase = r.phase + 4'h1;
                if (r.phase == `FS_SCLK_HALF - 4'h1) begin
                    // select rises one half serial clock period after last bit
                    next_r.csN = 1'b1;
                    next_r.state = flash_seq_pkg::H_GUARD;
                    // hold select high over exit or entry delay, else four cycles
                    if (r.opcode == `FS_OP_SLEEP_EXIT) begin
                        next_r.timer = SLEEP_EXIT_CYCLES - 32'h1;
                    end else if (r.opcode == `FS_OP_SLEEP_ENTRY) begin
                        next_r.timer = SLEEP_ENTRY_CYCLES - 32'h1;
                    end else begin
                        next_r.timer = 32'h0000_0003;
                    end
                end
            end
            flash_seq_pkg::H_GUARD, flash_seq_pkg::H_RSTWAIT: begin
                if (r.timer == 32'h0000_0000) begin
                    next_r.state = flash_seq_pkg::H_IDLE;
                end else begin
                    next_r.timer = r.timer - 32'h1;
                end
            end
            default: begin
                next_r.state = flash_seq_pkg::H_IDLE;
            end
        endcase
        // Register writes take effect at the access edge
        if (wrAcc && paddr[7:0] == `FS_REG_ADDR) begin
            next_r.addr = pwdata[23:0];
        end
        if (wrAcc && paddr[7:0] == `FS_REG_CMD && !busy) begin
            next_r.opcode = pwdata[7:0];
            next_r.withAddr = pwdata[`FS_CMD_WITH_ADDR];
            next_r.extra = pwdata[`FS_CMD_EXTRA_HI:`FS_CMD_EXTRA_LO];
            next_r.bitsLeft = frameLen + {3'h0, pwdata[`FS_CMD_EXTRA_HI:`FS_CMD_EXTRA_LO]};
            next_r.shiftOut = {pwdata[7:0], (pwdata[`FS_CMD_WITH_ADDR] ? r.addr : 24'h000000)};
            next_r.state = flash_seq_pkg::H_LEAD;
            next_r.phase = 4'h0;
            next_r.csN = 1'b0;
        end
        if (wrAcc && paddr[7:0] == `FS_REG_RSTCTL) begin
            next_r.resetHold = pwdata[0];
            if (pwdata[0]) begin
                // Holding reset abandons any frame in flight
                next_r.state = flash_seq_pkg::H_IDLE;
                next_r.csN = 1'b1;
                next_r.sclk = 1'b0;
            end else if (r.resetHold) begin
                next_r.state = flash_seq_pkg::H_RSTWAIT;
                next_r.timer = RESET_TO_SELECT_CYCLES - 32'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '{state: flash_seq_pkg::H_IDLE, csN: 1'b1, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = r.prdata;
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~mapped(paddr);
    assign link.sclk = r.sclk;
    assign link.csN = r.csN;
    assign link.mosi = r.mosi;
    assign link.rstN = ~r.resetHold;

endmodule // flash_host

// File: hdl/flash_link_if.sv
// Serial link between the flash host and the flash device.
// All four wires are driven by the host; the device only samples them.
`timescale 1ns/1ps
interface flash_link_if;
    logic sclk;
    logic csN;
    logic mosi;
    logic rstN;
    modport host (output sclk, output csN, output mosi, output rstN);
    modport device (input sclk, input csN, input mosi, input rstN);
endinterface

// File: hdl/flash_seq_pkg.sv
// Types for both ends of the serial flash command link.
// Assumes the constants header is on the include path.
`include "flash_seq_regs.svh"
package flash_seq_pkg;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'h0,
        ST_CYCLE = 3'h1,
        ST_SLEEP_WAIT = 3'h2,
        ST_SLEEP = 3'h3,
        ST_WAKE_WAIT = 3'h4,
        ST_RESET = 3'h5
    } dev_state_e;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_LEAD = 3'h1,
        H_BIT = 3'h2,
        H_TAIL = 3'h3,
        H_GUARD = 3'h4,
        H_RSTWAIT = 3'h5
    } host_state_e;

    typedef struct packed {
        dev_state_e state;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic [5:0] bitCnt;
        logic [31:0] shiftIn;
        logic [31:0] timer;
        logic write_unlock_latch;
        logic wholeArray;
        logic [8:0] target;
        logic [511:0] blank;
    } dev_s;

    typedef struct packed {
        host_state_e state;
        logic [31:0] timer;
        logic [3:0] phase;
        logic [31:0] shiftOut;
        logic [5:0] bitsLeft;
        logic [7:0] opcode;
        logic withAddr;
        logic [2:0] extra;
        logic [23:0] addr;
        logic resetHold;
        logic sclk;
        logic csN;
        logic mosi;
        logic [31:0] prdata;
    } host_s;

endpackage

// File: hdl/flash_seq_regs.svh
// Constants shared by both ends of the serial flash command link.
// Assumes a 100 MHz system clock on both ends.
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH

// System clock rate
`define FS_CLK_MHZ 100
// Self-timed durations in microseconds (plain defaults)
`define FS_SUB_WIPE_TIME_US 1000
`define FS_ARRAY_WIPE_TIME_US 5000
`define FS_SLEEP_ENTRY_DELAY_US 3
`define FS_SLEEP_EXIT_DELAY_US 30
`define FS_RESET_TO_SELECT_US 30
// Host serial clock half period in system cycles
`define FS_SCLK_HALF 4'h4
// Idle levels of the synchronised pins {rstN, mosi, csN, sclk}
`define FS_PIN_IDLE 4'hA

// Opcodes (plain defaults)
`define FS_OP_WRITE_UNLOCK 8'h11
`define FS_OP_SUB_WIPE 8'h22
`define FS_OP_ARRAY_WIPE 8'h33
`define FS_OP_SLEEP_ENTRY 8'h44
`define FS_OP_SLEEP_EXIT 8'h55

// Frame lengths in bits
`define FS_LEN_OPCODE 6'h08
`define FS_LEN_ADDR_CMD 6'h20

// Host register byte offsets
`define FS_REG_CMD 8'h00
`define FS_REG_ADDR 8'h04
`define FS_REG_STATUS 8'h08
`define FS_REG_RSTCTL 8'h0C
// Command register fields
`define FS_CMD_WITH_ADDR 8
`define FS_CMD_EXTRA_LO 9
`define FS_CMD_EXTRA_HI 11

`endif

// File: tb/flash_link_checker.sv
// Checker for the flash link wires and the device status outputs.
// Assumes instantiation beside the link interface in the bench top.
`timescale 1ns/1ps
module flash_link_checker (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic csN,
    input wire logic mosi,
    input wire logic rstN,
    input wire logic cycleRunning,
    input wire logic writeUnlock,
    input wire logic deepSleep,
    input wire logic standby,
    input wire logic resetMode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // ----------------------------------------
    // Framing and state steps
    // ----------------------------------------
    sequence frameOpen;
        $fell(csN);
    endsequence
    sequence wakeDecode;
        $fell(deepSleep) && rstN;
    endsequence
    idle_clock_a: assert property (csN |-> !sclk)
        else $error("serial clock high while deselected");
    frame_lead_a: assert property (frameOpen |-> !sclk [*4])
        else $error("no low lead before first bit");
    data_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("data moved while clock high");
    latch_drop_a: assert property ($rose(cycleRunning) |-> ##[0:2] !writeUnlock)
        else $error("unlock latch kept in erase cycle");
    sleep_alone_a: assert property (deepSleep |-> !cycleRunning && !standby && $stable(writeUnlock))
        else $error("sleep overlaps another state");
    // Deselect alone must never stand in for a busy device
    busy_standby_a: assert property (cycleRunning |-> !standby)
        else $error("standby while cycle runs");
    pin_reset_a: assert property (!rstN [*2] |-> ##[0:3] resetMode)
        else $error("reset pin not seen");
    reset_clear_a: assert property (resetMode && $past(resetMode) |->
        !cycleRunning && !writeUnlock)
        else $error("cycle or latch survive reset pin");
    sleep_delay_a: assert property ($rose(deepSleep) |-> $past(csN, 10))
        else $error("sleep entered before entry delay");
    wake_delay_a: assert property (wakeDecode |-> ##[10:40] standby)
        else $error("no standby after exit delay");
endmodule // flash_link_checker

// File: tb/serial_flash_erase_and_sleep_bench.sv
// Bench: APB host end driving the flash device end over the link.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
module serial_flash_erase_and_sleep_bench;
    logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, progMark, lastErr;
    logic cycleRunning, writeUnlock, deepSleep, standby, resetMode;
    logic [31:0] paddr, pwdata, prdata, q;
    logic [511:0] protMask, blankMap;
    logic [8:0] progIndex;
    int checked = 0;
    int miscompares = 0;
    flash_link_if link ();
    // Host keeps its default sleep waits, longer than the device's, so select stays high
    flash_host #(.RESET_TO_SELECT_CYCLES(20))
        u_flash_host (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    // Long subsector erase time so commands can land inside a running cycle
    flash_device #(.SUB_WIPE_CYCLES(1000), .ARRAY_WIPE_CYCLES(100), .SLEEP_ENTRY_CYCLES(20),
        .SLEEP_EXIT_CYCLES(20)) u_flash_device (.mclk(mclk), .arst_n(arst_n), .link(link),
        .protMask(protMask), .progMark(progMark), .progIndex(progIndex), .blankMap(blankMap),
        .cycleRunning(cycleRunning), .writeUnlock(writeUnlock), .deepSleep(deepSleep),
        .standby(standby), .resetMode(resetMode));
    flash_link_checker u_flash_link_checker (.mclk(mclk), .arst_n(arst_n), .sclk(link.sclk),
        .csN(link.csN), .mosi(link.mosi), .rstN(link.rstN), .cycleRunning(cycleRunning),
        .writeUnlock(writeUnlock), .deepSleep(deepSleep), .standby(standby),
        .resetMode(resetMode));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // One APB transfer; idle edge first so strobes never toggle twice at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h000000, a};
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Poll host busy until clear (the watchdog ends a hang), then let the device settle
    task automatic idle();
        repeat (2) @(posedge mclk);
        do begin
            apb(1'b0, `FS_REG_STATUS, 32'h0);
        end while (q[0] !== 1'b0);
        repeat (8) @(posedge mclk);
    endtask
    task automatic run(input logic [7:0] op, input logic wa, input logic [31:0] ad,
                       input logic [2:0] ex);
        apb(1'b1, `FS_REG_ADDR, ad);
        apb(1'b1, `FS_REG_CMD, {20'h00000, ex, wa, op});
        idle();
    endtask
    task automatic check(input string nm, input logic [511:0] s, input logic [511:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic waitRun();
        while (cycleRunning === 1'b1) begin
            @(posedge mclk);
        end
        repeat (2) @(posedge mclk);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #500us;
        miscompares++;
        conclude();
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        {arst_n, psel, penable, pwrite, progMark, paddr, pwdata, progIndex} = '0;
        protMask = '0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        check("standby", standby, 1'b1);
        check("sleep", deepSleep, 1'b0);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped error", lastErr, 1'b1);
        apb(1'b1, `FS_REG_ADDR, 32'hA5123456);
        apb(1'b0, `FS_REG_ADDR, 32'h0);
        check("addr readback", q, 32'h00123456);
        $display("test power-up done");
        run(`FS_OP_SUB_WIPE, 1'b1, 32'h00005000, 3'h0);
        check("locked erase", cycleRunning, 1'b0);
        run(`FS_OP_WRITE_UNLOCK, 1'b0, 32'h0, 3'h0);
        check("latch set", writeUnlock, 1'b1);
        run(`FS_OP_SUB_WIPE, 1'b1, 32'h00E05123, 3'h0);
        check("sub running", cycleRunning, 1'b1);
        check("latch cleared", writeUnlock, 1'b0);
        run(`FS_OP_SLEEP_ENTRY, 1'b0, 32'h0, 3'h0);
        check("busy sleep", deepSleep, 1'b0);
        check("still running", cycleRunning, 1'b1);
        waitRun();
        check("sub blank", blankMap, 512'h20);
        $display("test subsector wipe done");
        run(`FS_OP_WRITE_UNLOCK, 1'b0, 32'h0, 3'h0);
        run(`FS_OP_SUB_WIPE, 1'b1, 32'h00005000, 3'h1);
        check("33 bit wipe", cycleRunning, 1'b0);
        protMask <= 512'h80;
        run(`FS_OP_SUB_WIPE, 1'b1, 32'h00007000, 3'h0);
        check("protected wipe", cycleRunning, 1'b0);
        run(`FS_OP_ARRAY_WIPE, 1'b0, 32'h0, 3'h0);
        check("protected array", cycleRunning, 1'b0);
        protMask <= '0;
        run(`FS_OP_ARRAY_WIPE, 1'b0, 32'h0, 3'h1);
        check("9 bit array", cycleRunning, 1'b0);
        run(`FS_OP_ARRAY_WIPE, 1'b0, 32'h0, 3'h0);
        check("array running", cycleRunning, 1'b1);
        waitRun();
        check("array blank", blankMap, {512{1'b1}});
        $display("test array wipe done");
        run(`FS_OP_SLEEP_ENTRY, 1'b0, 32'h0, 3'h2);
        check("long entry", deepSleep, 1'b0);
        run(`FS_OP_SLEEP_ENTRY, 1'b0, 32'h0, 3'h0);
        check("asleep", deepSleep, 1'b1);
        check("no standby", standby, 1'b0);
        run(`FS_OP_WRITE_UNLOCK, 1'b0, 32'h0, 3'h0);
        check("sleep unlock", writeUnlock, 1'b0);
        run(`FS_OP_SLEEP_EXIT, 1'b0, 32'h0, 3'h1);
        check("long exit", deepSleep, 1'b1);
        run(`FS_OP_SLEEP_EXIT, 1'b0, 32'h0, 3'h0);
        check("awake", deepSleep, 1'b0);
        check("wake standby", standby, 1'b1);
        $display("test sleep done");
        progIndex <= 9'h009;
        progMark <= 1'b1;
        @(posedge mclk);
        progMark <= 1'b0;
        run(`FS_OP_WRITE_UNLOCK, 1'b0, 32'h0, 3'h0);
        run(`FS_OP_SUB_WIPE, 1'b1, 32'h00009000, 3'h0);
        apb(1'b1, `FS_REG_RSTCTL, 32'h1);
        repeat (6) @(posedge mclk);
        check("reset mode", resetMode, 1'b1);
        check("aborted", cycleRunning, 1'b0);
        apb(1'b1, `FS_REG_RSTCTL, 32'h0);
        idle();
        check("not wiped", blankMap[9], 1'b0);
        check("reset standby", standby, 1'b1);
        $display("test reset pin done");
        conclude();
    end
endmodule // serial_flash_erase_and_sleep_bench
